// >>> sma_pkg.sv
/*
 * Shared constants for the management-interrupt and wake-event aggregator.
 * Assumes the software-visible registers live outside and reach the block as plain ports.
 */
`default_nettype none

package sma_pkg;
   // Bit positions inside the second interrupt enable byte
   localparam int EN2_PIN_BIT = 7;
   localparam int EN2_SERIRQ_BIT = 6;
   localparam int EN2_WAKE_BIT = 5;
   // Bit position inside the third wake enable byte
   localparam int WAKE3_ROUTED_BIT = 3;
   // Pin control byte fields
   localparam int PINCTL_BUFFER_BIT = 7;
   localparam int PINCTL_POLARITY_BIT = 1;
   // Source counts
   localparam int N_PERIPH = 8;
   localparam int N_GPIO = 19;
   localparam int N_TACH = 2;
   localparam int N_MISC = 5;
   // Positions of the fixed wake sources in the misc vector
   localparam int MISC_RING_ONE = 0;
   localparam int MISC_RING_TWO = 1;
   localparam int MISC_KBD = 2;
   localparam int MISC_MOUSE = 3;
   localparam int MISC_IR = 4;
   // Stages before edge detection is trusted after reset
   localparam int ARM_STAGES = 3;
   // Reset values
   localparam logic STS_RESET = 1'b0;
   localparam logic PIN_O_RESET = 1'b0;
   localparam logic PIN_OE_RESET = 1'b0;
endpackage : sma_pkg

`default_nettype wire

// >>> sma_edge_sync.sv
/*
 * Two-flop synchroniser with per-bit edge selection: rising, falling or both.
 * Assumes pins may be asynchronous; edges are suppressed until the pipeline holds real samples.
 */
`default_nettype none

module sma_edge_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [W-1:0] pin_in,
   input wire logic [W-1:0] falling_sel,
   input wire logic [W-1:0] both_sel,
   output logic [W-1:0] edge_evt
);
   import sma_pkg::*;

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [ARM_STAGES-1:0] armed_r;

   // Only s2_r reads s1_r; edges are taken from s2_r and s3_r
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Avoids a false edge from reset zeros meeting a pin that already sits high
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         armed_r <= '0;
      end else begin
         armed_r <= {armed_r[ARM_STAGES-2:0], 1'b1};
      end
   end

   always_comb begin
      edge_evt = '0;
      if (armed_r[ARM_STAGES-1]) begin
         edge_evt = (s2_r & ~s3_r & ~falling_sel & ~both_sel)
                  | (~s2_r & s3_r & falling_sel & ~both_sel)
                  | ((s2_r ^ s3_r) & both_sel);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_either_edge: assert property (armed_r[ARM_STAGES-1] && ((s2_r ^ s3_r) & both_sel) != '0
      |-> (edge_evt & both_sel) == ((s2_r ^ s3_r) & both_sel))
      else $error("either-edge transition missed");
   a_polarity_edge: assert property ((edge_evt & ~both_sel & ~falling_sel) != '0
      |-> ((edge_evt & ~both_sel & ~falling_sel) & ~s2_r) == '0)
      else $error("non-inverted edge taken on falling transition");
endmodule : sma_edge_sync

`default_nettype wire

// >>> sma_pin_drive.sv
/*
 * Output pin stage with programmable active level and open-drain or push-pull buffer.
 * Assumes an external pull-up sets the pin level whenever the enable is low.
 */
`default_nettype none

module sma_pin_drive (
   input wire logic mclk,
   input wire logic reset,
   input wire logic req,
   input wire logic active_high,
   input wire logic push_pull,
   output logic pin_o,
   output logic pin_oe,
   output logic active_r
);
   import sma_pkg::*;

   logic level;

   assign level = req ? active_high : ~active_high;

   // Open drain only ever pulls low; a high level is left to the pull-up
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pin_o <= PIN_O_RESET;
         pin_oe <= PIN_OE_RESET;
         active_r <= STS_RESET;
      end else begin
         pin_o <= push_pull & level;
         pin_oe <= push_pull | ~level;
         active_r <= req;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_od_active_low: assert property (req && !push_pull && !active_high |=> pin_oe && !pin_o)
      else $error("open-drain active-low pin not pulled low");
   a_pp_level: assert property (push_pull |=> pin_oe && (pin_o == ($past(req) ~^ $past(active_high))))
      else $error("push-pull pin level wrong");
endmodule : sma_pin_drive

`default_nettype wire

// >>> sma_event_aggregator.sv
/*
 * Group management interrupt and wake-event aggregator with status latches and pin outputs.
 * Assumes status writes and reads arrive as one-cycle pulses from an outside register file.
 */
// Overview of operation
// - Latch GPIO and tachometer events, gate with enables
// - Peripheral events pass live through their enables
// - Infrared flag clears on status-two read
// - GPIO status clears on write of one
// - Polarity bit selects rising or falling edge
// - Either-edge mode sets on both edges
// - Enable bit 7 gates interrupt pin
// - Enable bit 6 routes to serial IRQ2
// - Enable bit 5 feeds routed interrupt status
// - Interrupt pin polarity and buffer programmable
// - Wake pin polarity and buffer programmable
// - Global wake enable gates the wake pin
// - Global wake status ignores global enable
// - Global status holds while events pending
// - Ring, infrared, keyboard, mouse, GPIO, tachometer wake
// - GPIO wake status edges, write-one clear
// - Routed status shows gated group interrupt
// - Routed enable and status drive wake pin
`default_nettype none

module sma_event_aggregator #(
   parameter int NP = sma_pkg::N_PERIPH,
   parameter int NG = sma_pkg::N_GPIO,
   parameter int NT = sma_pkg::N_TACH
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [NP-1:0] periph_irq,
   input wire logic [NP-1:0] periph_smi_en,
   input wire logic ir_event,
   input wire logic ir_smi_en,
   input wire logic interrupt_status_two_read,
   output logic infrared_interrupt_flag,
   input wire logic [NG-1:0] gpio_in,
   input wire logic [NG-1:0] gpio_polarity,
   input wire logic [NG-1:0] either_edge_trigger,
   input wire logic [NG-1:0] gpio_smi_en,
   input wire logic [NG-1:0] gpio_smi_clr,
   output logic [NG-1:0] gpio_smi_sts,
   input wire logic [NG-1:0] gpio_wake_en,
   input wire logic [NG-1:0] gpio_wake_clr,
   output logic [NG-1:0] gpio_wake_sts,
   input wire logic [NT-1:0] tach_event,
   input wire logic [NT-1:0] tach_smi_en,
   input wire logic [NT-1:0] tach_smi_clr,
   output logic [NT-1:0] tach_smi_sts,
   input wire logic [NT-1:0] tach_wake_en,
   input wire logic [NT-1:0] tach_wake_clr,
   output logic [NT-1:0] tach_wake_sts,
   input wire logic ring_indicator_one,
   input wire logic ring_indicator_two,
   input wire logic kbd_data,
   input wire logic mouse_data,
   input wire logic [sma_pkg::N_MISC-1:0] misc_wake_en,
   input wire logic [sma_pkg::N_MISC-1:0] misc_wake_clr,
   output logic [sma_pkg::N_MISC-1:0] misc_wake_sts,
   input wire logic [7:0] interrupt_enable_two,
   input wire logic [7:0] wake_enable_three,
   input wire logic routed_interrupt_clr,
   output logic routed_interrupt_status,
   input wire logic global_wake_enable,
   input wire logic global_wake_clr,
   output logic global_wake_status,
   input wire logic [7:0] interrupt_pin_control,
   input wire logic [7:0] wake_pin_control,
   output logic internal_group_interrupt,
   output logic serirq_irq2,
   output logic group_interrupt_pin_o,
   output logic group_interrupt_pin_oe,
   output logic wake_event_pin_o,
   output logic wake_event_pin_oe
);
   import sma_pkg::*;

   // Set-and-clear helper: a set in the clearing cycle wins
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction : sticky

   logic [NG-1:0] gpio_edge;
   logic [N_MISC-2:0] pin_edge;
   logic [N_MISC-1:0] misc_evt;
   logic smi_group;
   logic routed_gated;
   logic wake_pending;
   logic wake_req;
   logic smi_pin_active;
   logic wake_pin_active;
   logic smi_pin_en;
   logic serirq_en;
   logic smi_wake_en;
   logic routed_en;

   assign smi_pin_en = interrupt_enable_two[EN2_PIN_BIT];
   assign serirq_en = interrupt_enable_two[EN2_SERIRQ_BIT];
   assign smi_wake_en = interrupt_enable_two[EN2_WAKE_BIT];
   assign routed_en = wake_enable_three[WAKE3_ROUTED_BIT];

   sma_edge_sync #(.W(NG)) u_gpio_edge (
      .mclk(mclk),
      .reset(reset),
      .pin_in(gpio_in),
      .falling_sel(gpio_polarity),
      .both_sel(either_edge_trigger),
      .edge_evt(gpio_edge)
   );

   // Ring indicators and keyboard/mouse data are active on their falling edge
   sma_edge_sync #(.W(N_MISC - 1)) u_pin_edge (
      .mclk(mclk),
      .reset(reset),
      .pin_in({mouse_data, kbd_data, ring_indicator_two, ring_indicator_one}),
      .falling_sel('1),
      .both_sel('0),
      .edge_evt(pin_edge)
   );

   assign misc_evt = {ir_event, pin_edge};

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         gpio_smi_sts <= '0;
         tach_smi_sts <= '0;
      end else begin
         for (int i = 0; i < NG; i++) begin
            gpio_smi_sts[i] <= sticky(gpio_smi_sts[i], gpio_edge[i], gpio_smi_clr[i]);
         end
         for (int i = 0; i < NT; i++) begin
            tach_smi_sts[i] <= sticky(tach_smi_sts[i], tach_event[i], tach_smi_clr[i]);
         end
      end
   end

   // A read that coincides with a new infrared event keeps the flag set
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         infrared_interrupt_flag <= STS_RESET;
      end else begin
         infrared_interrupt_flag <= sticky(infrared_interrupt_flag, ir_event, interrupt_status_two_read);
      end
   end

   // Peripheral events are not latched here, so they fall as soon as the source clears
   assign smi_group = (|(periph_irq & periph_smi_en))
                    | (infrared_interrupt_flag & ir_smi_en)
                    | (|(gpio_smi_sts & gpio_smi_en))
                    | (|(tach_smi_sts & tach_smi_en));

   assign routed_gated = smi_group & smi_wake_en;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         internal_group_interrupt <= STS_RESET;
         serirq_irq2 <= STS_RESET;
         routed_interrupt_status <= STS_RESET;
      end else begin
         internal_group_interrupt <= smi_group;
         serirq_irq2 <= smi_group & serirq_en;
         // Stays set while the gated interrupt is still active, even under a clear
         routed_interrupt_status <= sticky(routed_interrupt_status, routed_gated, routed_interrupt_clr);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         gpio_wake_sts <= '0;
         tach_wake_sts <= '0;
         misc_wake_sts <= '0;
      end else begin
         for (int i = 0; i < NG; i++) begin
            gpio_wake_sts[i] <= sticky(gpio_wake_sts[i], gpio_edge[i], gpio_wake_clr[i]);
         end
         for (int i = 0; i < NT; i++) begin
            tach_wake_sts[i] <= sticky(tach_wake_sts[i], tach_event[i], tach_wake_clr[i]);
         end
         for (int i = 0; i < N_MISC; i++) begin
            misc_wake_sts[i] <= sticky(misc_wake_sts[i], misc_evt[i], misc_wake_clr[i]);
         end
      end
   end

   assign wake_pending = (|(gpio_wake_sts & gpio_wake_en))
                       | (|(tach_wake_sts & tach_wake_en))
                       | (|(misc_wake_sts & misc_wake_en))
                       | (routed_interrupt_status & routed_en);

   // Global status cannot be cleared while any enabled event is still pending
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         global_wake_status <= STS_RESET;
      end else begin
         global_wake_status <= sticky(global_wake_status, wake_pending, global_wake_clr);
      end
   end

   assign wake_req = global_wake_enable & wake_pending;

   sma_pin_drive u_smi_pin (
      .mclk(mclk),
      .reset(reset),
      .req(smi_group & smi_pin_en),
      .active_high(interrupt_pin_control[PINCTL_POLARITY_BIT]),
      .push_pull(interrupt_pin_control[PINCTL_BUFFER_BIT]),
      .pin_o(group_interrupt_pin_o),
      .pin_oe(group_interrupt_pin_oe),
      .active_r(smi_pin_active)
   );

   sma_pin_drive u_wake_pin (
      .mclk(mclk),
      .reset(reset),
      .req(wake_req),
      .active_high(wake_pin_control[PINCTL_POLARITY_BIT]),
      .push_pull(wake_pin_control[PINCTL_BUFFER_BIT]),
      .pin_o(wake_event_pin_o),
      .pin_oe(wake_event_pin_oe),
      .active_r(wake_pin_active)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_gpio_hit;
      (gpio_edge != '0);
   endsequence

   sequence s_gpio_latched;
      ((gpio_smi_sts & $past(gpio_edge)) == $past(gpio_edge)) && ((gpio_wake_sts & $past(gpio_edge)) == $past(gpio_edge));
   endsequence

   a_gpio_latch: assert property (s_gpio_hit |=> s_gpio_latched)
      else $error("GPIO edge not latched");
   a_gpio_clear: assert property ((gpio_smi_clr & ~gpio_edge) != '0
      |=> (gpio_smi_sts & $past(gpio_smi_clr & ~gpio_edge)) == '0)
      else $error("GPIO status not cleared by write of one");
   a_gpio_keep: assert property ((gpio_smi_sts & ~gpio_smi_clr) != '0
      |=> (gpio_smi_sts & $past(gpio_smi_sts & ~gpio_smi_clr)) == $past(gpio_smi_sts & ~gpio_smi_clr))
      else $error("GPIO status lost without a clear");
   a_periph_path: assert property ((|(periph_irq & periph_smi_en)) |=> internal_group_interrupt)
      else $error("enabled peripheral event missing from group interrupt");
   a_ir_read_clear: assert property (interrupt_status_two_read && !ir_event |=> !infrared_interrupt_flag)
      else $error("infrared flag survived a status read");
   a_pin_gate: assert property (!smi_pin_en |=> !smi_pin_active)
      else $error("interrupt pin active while pin enable clear");
   a_pin_on: assert property (smi_group && smi_pin_en |=> smi_pin_active)
      else $error("interrupt pin not driven by group interrupt");
   a_irq2_route: assert property (serirq_irq2 |-> $past(serirq_en) && $past(smi_group))
      else $error("IRQ2 slot driven without enable and source");
   a_routed_set: assert property (routed_gated |=> routed_interrupt_status ##1 routed_interrupt_status || !$past(routed_gated))
      else $error("routed status not set by gated interrupt");
   a_wake_gate: assert property (!global_wake_enable |=> !wake_pin_active)
      else $error("wake pin active with global enable clear");
   a_wake_routed: assert property (global_wake_enable && routed_en && routed_interrupt_status |=> wake_pin_active)
      else $error("routed interrupt did not drive wake pin");
   a_wake_hold: assert property (wake_pending |=> global_wake_status)
      else $error("global wake status clear while events pending");

   sequence s_ir_enabled_hit;
      (ir_event && ir_smi_en) ##1 ir_smi_en;
   endsequence

   sequence s_routed_path;
      (routed_gated && routed_en && global_wake_enable) ##1 (routed_en && global_wake_enable);
   endsequence

   a_tach_latch: assert property (tach_event != '0
      |=> (tach_smi_sts & tach_wake_sts & $past(tach_event)) == $past(tach_event))
      else $error("tachometer event not latched");
   a_tach_clear: assert property ((tach_smi_clr & ~tach_event) != '0
      |=> (tach_smi_sts & $past(tach_smi_clr & ~tach_event)) == '0)
      else $error("tachometer status not cleared by write of one");
   a_misc_latch: assert property (misc_evt != '0 |=> (misc_wake_sts & $past(misc_evt)) == $past(misc_evt))
      else $error("wake source event not latched");
   a_misc_clear: assert property ((misc_wake_clr & ~misc_evt) != '0
      |=> (misc_wake_sts & $past(misc_wake_clr & ~misc_evt)) == '0)
      else $error("wake source status not cleared by write of one");
   a_gpio_wake_clear: assert property ((gpio_wake_clr & ~gpio_edge) != '0
      |=> (gpio_wake_sts & $past(gpio_wake_clr & ~gpio_edge)) == '0)
      else $error("GPIO wake status not cleared by write of one");
   a_ir_set: assert property (ir_event |=> infrared_interrupt_flag)
      else $error("infrared flag not set by event");
   a_ir_group: assert property (s_ir_enabled_hit |=> internal_group_interrupt)
      else $error("enabled infrared flag missing from group interrupt");
   a_group_drop: assert property (!smi_group |=> !internal_group_interrupt)
      else $error("group interrupt held without an enabled source");
   a_irq2_on: assert property (smi_group && serirq_en |=> serirq_irq2)
      else $error("IRQ2 slot not driven by enabled group interrupt");
   a_routed_gate: assert property (!routed_interrupt_status && !routed_gated |=> !routed_interrupt_status)
      else $error("routed status set without bit 5 and group interrupt");
   a_routed_clear: assert property (routed_interrupt_clr && !routed_gated |=> !routed_interrupt_status)
      else $error("routed status not cleared by write of one");
   a_routed_wake: assert property (s_routed_path |=> wake_pin_active)
      else $error("gated group interrupt did not reach wake pin");
   a_global_clear: assert property (global_wake_clr && !wake_pending |=> !global_wake_status)
      else $error("global wake status not cleared with nothing pending");
   a_wake_on: assert property (wake_req |=> wake_pin_active)
      else $error("wake pin idle with enabled pending event");
   a_wake_od_active: assert property (wake_req && !wake_pin_control[PINCTL_BUFFER_BIT]
      && !wake_pin_control[PINCTL_POLARITY_BIT] |=> wake_event_pin_oe && !wake_event_pin_o)
      else $error("open-drain active-low wake pin not pulled low");
   a_smi_pin_idle: assert property (!(smi_group && smi_pin_en) && !interrupt_pin_control[PINCTL_BUFFER_BIT]
      && !interrupt_pin_control[PINCTL_POLARITY_BIT] |=> !group_interrupt_pin_oe)
      else $error("open-drain interrupt pin driven while idle");
endmodule : sma_event_aggregator

`default_nettype wire

// >>> sma_host_model.sv
/*
 * Host chipset view of one output pin of the aggregator: wire level and active detection.
 * Assumes an external pull-up holds the wire high whenever no party drives it.
 */
`default_nettype none

module sma_host_model (
   input wire logic pin_o,
   input wire logic pin_oe,
   input wire logic active_high,
   output logic level,
   output logic seen_active
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released wire shows the pull-up level, never the last driven value
   assign level = pin_oe ? pin_o : 1'b1;
   // Active judged against the programmed level, as the chipset input would see it
   assign seen_active = (level === active_high);
endmodule : sma_host_model

`default_nettype wire

// >>> sma_event_aggregator_test.sv
/*
 * Directed bench for the event aggregator: level and pulse stimulus, status and pin checks.
 * Assumes pull-ups on both output pins, resolved by the host model instances.
 */
`default_nettype none

module sma_event_aggregator_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sma_pkg::*;
   logic mclk = 1'b0, reset = 1'b1;
   logic [7:0] p_irq = '0, p_en = '0, en2 = '0, wen3 = '0, ipc = '0, wpc = '0;
   logic ir_ev = 1'b0, ir_en = 1'b0, sts2_rd = 1'b0, r_clr = 1'b0, gw_en = 1'b0, gw_clr = 1'b0;
   logic [N_GPIO-1:0] g_in = '0, g_pol = '0, g_both = '0, g_sen = '0, g_sclr = '0, g_wen = '0, g_wclr = '0;
   logic [1:0] t_ev = '0, t_sen = '0, t_sclr = '0, t_wen = '0, t_wclr = '0;
   logic ri1 = 1'b1, ri2 = 1'b1, kbd = 1'b1, mse = 1'b1;
   logic [N_MISC-1:0] m_wen = '0, m_wclr = '0, m_wsts;
   logic ir_flag, rsts, gsts, grp, irq2, ipo, ipoe, wpo, wpoe, int_lvl, int_act, wake_lvl, wake_act;
   logic [N_GPIO-1:0] g_ssts, g_wsts;
   logic [1:0] t_ssts, t_wsts;
   int err_total = 0, checks = 0;

   sma_event_aggregator i_dut (.mclk(mclk), .reset(reset), .periph_irq(p_irq), .periph_smi_en(p_en),
      .ir_event(ir_ev), .ir_smi_en(ir_en), .interrupt_status_two_read(sts2_rd),
      .infrared_interrupt_flag(ir_flag), .gpio_in(g_in), .gpio_polarity(g_pol), .either_edge_trigger(g_both),
      .gpio_smi_en(g_sen), .gpio_smi_clr(g_sclr), .gpio_smi_sts(g_ssts), .gpio_wake_en(g_wen),
      .gpio_wake_clr(g_wclr), .gpio_wake_sts(g_wsts), .tach_event(t_ev), .tach_smi_en(t_sen),
      .tach_smi_clr(t_sclr), .tach_smi_sts(t_ssts), .tach_wake_en(t_wen), .tach_wake_clr(t_wclr),
      .tach_wake_sts(t_wsts), .ring_indicator_one(ri1), .ring_indicator_two(ri2), .kbd_data(kbd),
      .mouse_data(mse), .misc_wake_en(m_wen), .misc_wake_clr(m_wclr), .misc_wake_sts(m_wsts),
      .interrupt_enable_two(en2), .wake_enable_three(wen3), .routed_interrupt_clr(r_clr),
      .routed_interrupt_status(rsts), .global_wake_enable(gw_en), .global_wake_clr(gw_clr),
      .global_wake_status(gsts), .interrupt_pin_control(ipc), .wake_pin_control(wpc),
      .internal_group_interrupt(grp), .serirq_irq2(irq2), .group_interrupt_pin_o(ipo),
      .group_interrupt_pin_oe(ipoe), .wake_event_pin_o(wpo), .wake_event_pin_oe(wpoe));
   sma_host_model i_int_host (.pin_o(ipo), .pin_oe(ipoe), .active_high(ipc[PINCTL_POLARITY_BIT]),
      .level(int_lvl), .seen_active(int_act));
   sma_host_model i_wake_host (.pin_o(wpo), .pin_oe(wpoe), .active_high(wpc[PINCTL_POLARITY_BIT]),
      .level(wake_lvl), .seen_active(wake_act));

   always #20 mclk = ~mclk;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task automatic done(input string nm);
      $display("test %s ended", nm);
   endtask : done
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   // Whole run is about 80 cycles; the 3000-cycle limit, over thirty times that, means a hang
   initial begin
      #(40 * 3000);
      err_total++;
      give_verdict();
   end

   initial begin
      cyc(6);
      reset = 1'b0;
      chk("gpio_smi_sts", 0, g_ssts);
      chk("int_level", 1, int_lvl);
      chk("wake_level", 1, wake_lvl);
      cyc(4);
      chk("misc_wake_sts", 0, m_wsts);
      g_pol[2:1] = 2'b11;
      g_both[2] = 1'b1;
      g_in[2:0] = 3'b111;
      cyc(6);
      chk("gpio_smi_sts", 19'h5, g_ssts);
      chk("gpio_wake_sts", 19'h5, g_wsts);
      g_sclr = 19'h1;
      g_wclr = 19'h1;
      cyc(1);
      g_sclr = '0;
      g_wclr = '0;
      cyc(1);
      chk("gpio_smi_sts", 19'h4, g_ssts);
      chk("gpio_wake_sts", 19'h4, g_wsts);
      g_sclr = 19'h4;
      cyc(1);
      g_sclr = '0;
      g_in[2:0] = 3'b000;
      cyc(6);
      chk("gpio_smi_sts", 19'h6, g_ssts);
      done("gpio_edges");
      g_sen = 19'h2;
      en2 = 8'h80;
      cyc(3);
      chk("group", 1, grp);
      chk("int_pin", 2'b10, {ipoe, ipo});
      chk("int_active", 1, int_act);
      en2 = 8'h40;
      cyc(3);
      chk("int_pin_oe", 0, ipoe);
      chk("irq2", 1, irq2);
      ipc = 8'h82;
      en2 = 8'h80;
      cyc(3);
      chk("int_pin", 2'b11, {ipoe, ipo});
      g_sen = '0;
      cyc(3);
      chk("int_active", 0, int_act);
      done("group_pin");
      t_sen = 2'b10;
      t_ev = 2'b10;
      cyc(1);
      t_ev = '0;
      cyc(2);
      chk("tach_smi_sts", 2'b10, t_ssts);
      chk("tach_wake_sts", 2'b10, t_wsts);
      chk("group", 1, grp);
      t_sclr = 2'b10;
      cyc(1);
      t_sclr = '0;
      cyc(2);
      chk("group", 0, grp);
      p_en = 8'h08;
      p_irq = 8'h08;
      cyc(2);
      chk("group", 1, grp);
      p_irq = '0;
      cyc(2);
      chk("group", 0, grp);
      ir_ev = 1'b1;
      ir_en = 1'b1;
      cyc(1);
      ir_ev = 1'b0;
      cyc(1);
      chk("ir_flag", 1, ir_flag);
      chk("group", 1, grp);
      chk("misc_wake_sts", 5'h10, m_wsts);
      sts2_rd = 1'b1;
      m_wclr = 5'h10;
      cyc(1);
      sts2_rd = 1'b0;
      m_wclr = '0;
      cyc(2);
      chk("ir_flag", 0, ir_flag);
      chk("group", 0, grp);
      done("sources");
      m_wen = 5'h01;
      ri1 = 1'b0;
      ri2 = 1'b0;
      kbd = 1'b0;
      mse = 1'b0;
      cyc(6);
      chk("misc_wake_sts", 5'h0f, m_wsts);
      chk("global_wake_status", 1, gsts);
      chk("wake_active", 0, wake_act);
      gw_clr = 1'b1;
      cyc(1);
      gw_clr = 1'b0;
      cyc(2);
      chk("global_wake_status", 1, gsts);
      gw_en = 1'b1;
      cyc(2);
      chk("wake_pin", 2'b10, {wpoe, wpo});
      wpc = 8'h82;
      cyc(2);
      chk("wake_pin", 2'b11, {wpoe, wpo});
      m_wclr = 5'h01;
      cyc(1);
      m_wclr = '0;
      gw_clr = 1'b1;
      cyc(1);
      gw_clr = 1'b0;
      cyc(2);
      chk("global_wake_status", 0, gsts);
      chk("wake_active", 0, wake_act);
      chk("misc_wake_sts", 5'h0e, m_wsts);
      done("wake");
      p_irq = 8'h08;
      cyc(3);
      chk("routed_status", 0, rsts);
      en2 = 8'h20;
      wen3 = 8'h08;
      cyc(3);
      chk("routed_status", 1, rsts);
      chk("wake_active", 1, wake_act);
      chk("global_wake_status", 1, gsts);
      p_irq = '0;
      cyc(2);
      r_clr = 1'b1;
      cyc(1);
      r_clr = 1'b0;
      cyc(2);
      chk("routed_status", 0, rsts);
      chk("wake_active", 0, wake_act);
      done("routed");
      give_verdict();
   end
endmodule : sma_event_aggregator_test

`default_nettype wire
